// file: rtl/lppsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module lppsc_top
  import lppsc_pkg::*;
#(
  parameter int N_PINS = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // power-mode controller
  input wire lppsc_state_t pmode_i,
  // peripheral functions, per pin
  input wire logic [N_PINS-1:0] periph_act_i,
  input wire logic [N_PINS-1:0] periph_oe_i,
  input wire logic [N_PINS-1:0] periph_do_i,
  // pads
  input wire logic [N_PINS-1:0] pad_di_i,
  output lppsc_pad_t [N_PINS-1:0] pad_o,
  // internal side of the pads
  output logic [N_PINS-1:0] core_di_o,
  output logic [N_PINS-1:0] blocked_o,
  // oscillators and state
  output logic main_osc_en_o,
  output logic sub_osc_en_o,
  output lppsc_state_t state_o
);

  // ****************************************************
  // elaboration check
  // ****************************************************
  if (N_PINS < 1 || N_PINS * FUNC_W > 32) begin : g_chk
    $error("lppsc_top: N_PINS must be 1 to 8");
  end

  // ****************************************************
  // pad decode
  // ****************************************************
  // state groups
  function automatic logic in_rst(input lppsc_state_t st);
    in_rst = (st == ST_POR) | (st == ST_INIT_LOW) | (st == ST_IRST);
  endfunction

  function automatic logic in_lowpwr(input lppsc_state_t st);
    in_lowpwr = (st == ST_TMR_MAIN) | (st == ST_TMR_SUB) |
                (st == ST_RTC) | (st == ST_STOP);
  endfunction

  function automatic logic in_deep(input lppsc_state_t st);
    in_deep = (st == ST_DS_RTC) | (st == ST_DS_STOP);
  endfunction

  function automatic logic main_stopped(input lppsc_state_t st);
    main_stopped = (st == ST_TMR_SUB) | (st == ST_RTC) |
                   (st == ST_STOP) | in_deep(st);
  endfunction

  function automatic logic sub_stopped(input lppsc_state_t st,
                                       input logic sstop);
    sub_stopped = sstop & ((st == ST_STOP) | (st == ST_DS_STOP));
  endfunction

  // per-pin drive, pull and input gating
  function automatic lppsc_pad_t pad_dec(input lppsc_state_t st,
                                         input lppsc_func_t fn,
                                         input logic standby_pin_level,
                                         input logic sstop,
                                         input lppsc_pad_t run_v,
                                         input lppsc_pad_t hold_v,
                                         input lppsc_pad_t gpio_v);
    lppsc_pad_t r;
    lppsc_pad_t gpio0;
    r = PAD_HIZ;
    gpio0 = gpio_v;
    gpio0.ie = 1'b0;
    case (fn)
      FN_MODE_IN, FN_SUB_XIN: begin
        r = PAD_IN;
      end
      FN_GPIO: begin
        if (st == ST_RUN) r = run_v;
        else if (in_lowpwr(st)) r = standby_pin_level ? PAD_IN : hold_v;
        else if (in_deep(st)) r = standby_pin_level ? PAD_IN : gpio_v;
        else if (st == ST_DS_RET) r = gpio_v;
      end
      FN_NMI: begin
        if (st == ST_RUN) r = run_v;
        else if (in_lowpwr(st)) r = hold_v;
        else if (in_deep(st)) begin
          r = standby_pin_level ? PAD_WK : gpio_v;
          r.wk = 1'b1;
        end else if (st == ST_DS_RET) r = gpio_v;
      end
      FN_JTAG: begin
        if (st == ST_INIT_LOW || st == ST_IRST) r = PAD_PU;
        else if (st == ST_RUN) r = run_v;
        else if (st != ST_POR) r = hold_v;
      end
      FN_EXTINT: begin
        if (st == ST_RUN) r = run_v;
        else if (in_lowpwr(st)) r = hold_v;
        else if (in_deep(st)) r = standby_pin_level ? PAD_HIZ : gpio0;
        else if (st == ST_DS_RET) r = gpio_v;
      end
      FN_ANA_IN: begin
        if (st != ST_POR) r = PAD_ANA;
      end
      FN_ANA_OUT: begin
        if (st == ST_RUN) r = run_v;
        else if (st == ST_TMR_MAIN || st == ST_TMR_SUB) begin
          r = hold_v;
        end else if (in_lowpwr(st) || in_deep(st)) begin
          r = standby_pin_level ? PAD_HIZ : gpio0;
        end else if (st == ST_DS_RET) r = gpio_v;
      end
      FN_PERIPH: begin
        if (st == ST_INIT_LOW || st == ST_IRST) r = PAD_IN;
        else if (st == ST_RUN) r = run_v;
        else if (in_lowpwr(st)) r = hold_v;
        else if (st == ST_DS_RET) r = gpio_v;
      end
      FN_MAIN_XOUT: begin
        if (in_rst(st) || main_stopped(st)) r = PAD_HIZ;
        else if (st == ST_RUN) r = run_v;
        else if (!(st == ST_VB_RTC || st == ST_VB_RET)) r = hold_v;
      end
      FN_SUB_XOUT: begin
        if (st == ST_POR || sub_stopped(st, sstop)) r = PAD_HIZ;
        else if (st == ST_RUN) r = run_v;
        else r = hold_v;
      end
      FN_VB_GPIO, FN_VB_RES: begin
        if (st == ST_RUN) r = run_v;
        else if (st != ST_POR) r = hold_v;
      end
      default: begin
        r = PAD_HIZ;
      end
    endcase
    pad_dec = r;
  endfunction

  // setting disabled or prohibited for this function and state
  function automatic logic cfg_blocked(input lppsc_state_t st,
                                       input lppsc_func_t fn);
    logic r;
    r = 1'b0;
    case (fn)
      FN_GPIO, FN_NMI, FN_EXTINT, FN_ANA_OUT: begin
        r = in_rst(st);
      end
      FN_VB_GPIO: begin
        r = (st == ST_POR) | (st == ST_VB_RET);
      end
      default: begin
        r = 1'b0;
      end
    endcase
    cfg_blocked = r;
  endfunction

  // ****************************************************
  // bus slave
  // ****************************************************
  lppsc_wr_t wr;
  logic [ADDR_W-1:0] raddr;
  logic [31:0] rdata;

  lppsc_ahb u_ahb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hwdata_i(hwdata_i),
    .hready_i(hready_i),
    .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .rdata_i(rdata),
    .raddr_o(raddr),
    .wr_o(wr)
  );

  // ****************************************************
  // pad input synchroniser
  // ****************************************************
  logic [N_PINS-1:0] pad_di_s;

  lppsc_sync #(
    .W(N_PINS)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pad_di_i),
    .q_o(pad_di_s)
  );

  // ****************************************************
  // registers
  // ****************************************************
  logic spl_r;
  logic sstop_r;
  logic [N_PINS*FUNC_W-1:0] func_r;
  logic [N_PINS-1:0] port_out_r;
  logic [N_PINS-1:0] port_dir_r;

  // write strobes per register
  wire wr_stby = wr.en & (wr.addr == OFS_STBY_CTL);
  wire wr_wosc = wr.en & (wr.addr == OFS_WOSC_CTL);
  wire wr_func = wr.en & (wr.addr == OFS_FUNC_SEL);
  wire wr_pout = wr.en & (wr.addr == OFS_PORT_OUT);
  wire wr_pdir = wr.en & (wr.addr == OFS_PORT_DIR);

  // software-written control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spl_r <= RST_SPL;
      sstop_r <= RST_SOSC_STOP;
      func_r <= '0;
      port_out_r <= '0;
      port_dir_r <= '0;
    end else begin
      if (wr_stby) spl_r <= wr.data[SPL_BIT];
      if (wr_wosc) sstop_r <= wr.data[SOSC_STOP_BIT];
      if (wr_func) func_r <= wr.data[N_PINS*FUNC_W-1:0];
      if (wr_pout) port_out_r <= wr.data[N_PINS-1:0];
      if (wr_pdir) port_dir_r <= wr.data[N_PINS-1:0];
    end
  end

  // ****************************************************
  // power state tracker
  // ****************************************************
  lppsc_state_t state_r;
  lppsc_state_t state_nxt;
  wire state_chg = (state_nxt != state_r);

  // malformed requests are ignored, state stays put
  always_comb begin
    state_nxt = state_r;
    case (pmode_i)
      ST_POR, ST_INIT_LOW, ST_IRST, ST_RUN, ST_TMR_MAIN,
      ST_TMR_SUB, ST_RTC, ST_STOP, ST_DS_RTC, ST_DS_STOP,
      ST_DS_RET, ST_VB_RTC, ST_VB_RET: begin
        state_nxt = pmode_i;
      end
      default: begin
        state_nxt = state_r;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) state_r <= ST_POR;
    else state_r <= state_nxt;
  end

  // ****************************************************
  // per-pin control
  // ****************************************************
  lppsc_pad_t [N_PINS-1:0] pad_r;
  lppsc_pad_t [N_PINS-1:0] held_r;
  lppsc_pad_t [N_PINS-1:0] pad_nxt;
  logic [N_PINS-1:0] core_di_r;
  logic [N_PINS-1:0] blocked_r;
  logic [N_PINS-1:0] blk_nxt;

  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    lppsc_func_t fn;
    lppsc_pad_t port_v;
    lppsc_pad_t per_v;
    lppsc_pad_t run_v;
    lppsc_pad_t hold_v;

    // port and peripheral drive sources
    assign fn = lppsc_func_t'(func_r[i*FUNC_W +: FUNC_W]);
    assign port_v = '{oe: port_dir_r[i], dout: port_out_r[i],
                      pu: 1'b0, ie: 1'b1, ana: 1'b0, wk: 1'b0};
    assign per_v = '{oe: periph_oe_i[i], dout: periph_do_i[i],
                     pu: 1'b0, ie: 1'b1, ana: 1'b0, wk: 1'b0};
    assign run_v = periph_act_i[i] ? per_v : port_v;
    // on the entry edge the held value is the pad as it stands now
    assign hold_v = periph_act_i[i] ? per_v :
                    (state_chg ? pad_r[i] : held_r[i]);
    assign pad_nxt[i] = pad_dec(state_nxt, fn, spl_r, sstop_r,
                                run_v, hold_v, port_v);
    assign blk_nxt[i] = cfg_blocked(state_nxt, fn);
  end

  // held value taken from the pad on each state entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_r <= '0;
    end else if (state_chg) begin
      held_r <= pad_r;
    end
  end

  // pad controls and gated internal input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_r <= '0;
      core_di_r <= '0;
      blocked_r <= '0;
    end else begin
      for (int i = 0; i < N_PINS; i++) begin
        pad_r[i] <= pad_nxt[i];
        core_di_r[i] <= pad_nxt[i].ie & pad_di_s[i];
      end
      blocked_r <= blk_nxt;
    end
  end

  // ****************************************************
  // oscillator enables
  // ****************************************************
  logic main_en_r;
  logic sub_en_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_en_r <= 1'b1;
      sub_en_r <= 1'b1;
    end else begin
      main_en_r <= ~main_stopped(state_nxt);
      sub_en_r <= ~sub_stopped(state_nxt, sstop_r);
    end
  end

  // ****************************************************
  // read mux
  // ****************************************************
  always_comb begin
    rdata = RST_WORD;
    case (raddr)
      OFS_STBY_CTL: rdata[SPL_BIT] = spl_r;
      OFS_WOSC_CTL: rdata[SOSC_STOP_BIT] = sstop_r;
      OFS_FUNC_SEL: rdata[N_PINS*FUNC_W-1:0] = func_r;
      OFS_PORT_OUT: rdata[N_PINS-1:0] = port_out_r;
      OFS_PORT_DIR: rdata[N_PINS-1:0] = port_dir_r;
      OFS_STATE: rdata[ST_W-1:0] = state_r;
      OFS_PIN_IN: rdata[N_PINS-1:0] = core_di_r;
      OFS_BLOCKED: rdata[N_PINS-1:0] = blocked_r;
      default: rdata = RST_WORD;
    endcase
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign pad_o = pad_r;
  assign core_di_o = core_di_r;
  assign blocked_o = blocked_r;
  assign main_osc_en_o = main_en_r;
  assign sub_osc_en_o = sub_en_r;
  assign state_o = state_r;

endmodule
`default_nettype wire

// file: pkg/lppsc_pkg.sv
// What this block does
// - mode input pins keep their input path enabled in every state
// - mode-class gpio: blocked in reset, hold or hi-z/input, deep gpio or hi-z/input
// - nmi pin holds in standby, takes wakeup in deep standby, gpio on return
// - jtag pin hi-z at power-up, pulled up in reset, then holds
// - external interrupt pin holds in standby, deep standby forces input low
// - analog input: hi-z at power-up, then driver off, input 0, analog on
// - analog output, level 0: holds in timer, gpio input low in rtc/stop
// - analog output, level 1: holds in timer, hi-z input low in rtc/stop
// - main oscillator stops in sub timer, rtc, stop and deep standby; pin hi-z
// - battery sub clock input keeps input enabled everywhere, on return as well
// - sub osc stop control 0: sub crystal output holds in stop modes
// - sub osc stop control 1: sub oscillator stops, output hi-z in stop modes
// - battery resource pin hi-z at power-on, holds in every later state except run
// - battery gpio holds after reset; configuring it on vbat return prohibited
// - standby pin level is one bit in the standby mode control register
// - held pin follows a running peripheral, else the last port value
// - forced input presents constant low; hi-z disables the pin driver
package lppsc_pkg;

  // ****************************************************
  // pin functions
  // ****************************************************
  localparam int FUNC_W = 4;
  typedef enum logic [3:0] {
    FN_GPIO = 4'h0,
    FN_MODE_IN = 4'h1,
    FN_NMI = 4'h2,
    FN_JTAG = 4'h3,
    FN_EXTINT = 4'h4,
    FN_ANA_IN = 4'h5,
    FN_ANA_OUT = 4'h6,
    FN_PERIPH = 4'h7,
    FN_MAIN_XOUT = 4'h8,
    FN_SUB_XIN = 4'h9,
    FN_SUB_XOUT = 4'ha,
    FN_VB_GPIO = 4'hb,
    FN_VB_RES = 4'hc
  } lppsc_func_t;

  // ****************************************************
  // cpu power states, one-hot
  // ****************************************************
  localparam int ST_W = 13;
  typedef enum logic [12:0] {
    ST_POR = 13'h0001,
    ST_INIT_LOW = 13'h0002,
    ST_IRST = 13'h0004,
    ST_RUN = 13'h0008,
    ST_TMR_MAIN = 13'h0010,
    ST_TMR_SUB = 13'h0020,
    ST_RTC = 13'h0040,
    ST_STOP = 13'h0080,
    ST_DS_RTC = 13'h0100,
    ST_DS_STOP = 13'h0200,
    ST_DS_RET = 13'h0400,
    ST_VB_RTC = 13'h0800,
    ST_VB_RET = 13'h1000
  } lppsc_state_t;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic oe;
    logic dout;
    logic pu;
    logic ie;
    logic ana;
    logic wk;
  } lppsc_pad_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } lppsc_wr_t;

  localparam lppsc_pad_t PAD_HIZ = 6'b000000;
  localparam lppsc_pad_t PAD_IN = 6'b000100;
  localparam lppsc_pad_t PAD_PU = 6'b001100;
  localparam lppsc_pad_t PAD_ANA = 6'b000010;
  localparam lppsc_pad_t PAD_WK = 6'b000101;

  // ****************************************************
  // register map
  // ****************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STBY_CTL = 8'h00;
  localparam logic [7:0] OFS_WOSC_CTL = 8'h04;
  localparam logic [7:0] OFS_FUNC_SEL = 8'h08;
  localparam logic [7:0] OFS_PORT_OUT = 8'h0c;
  localparam logic [7:0] OFS_PORT_DIR = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [7:0] OFS_PIN_IN = 8'h18;
  localparam logic [7:0] OFS_BLOCKED = 8'h1c;
  localparam int SPL_BIT = 0;
  localparam int SOSC_STOP_BIT = 0;
  localparam logic RST_SPL = 1'b0;
  localparam logic RST_SOSC_STOP = 1'b0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage

// file: rtl/lppsc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module lppsc_sync
  import lppsc_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // asynchronous levels in, synchronous out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // ****************************************************
  // two-stage synchroniser
  // ****************************************************
  // first stage feeds the second stage only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule
`default_nettype wire

// file: rtl/lppsc_ahb.sv
`timescale 1ns/100ps
`default_nettype none
module lppsc_ahb
  import lppsc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // register side
  input wire logic [31:0] rdata_i,
  output logic [ADDR_W-1:0] raddr_o,
  output lppsc_wr_t wr_o
);

  logic hready_r;
  logic wpend_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0] hrdata_r;
  logic aphase;

  // ****************************************************
  // address phase decode
  // ****************************************************
  // only word transfers are issued; hsize is not checked
  assign aphase = hsel_i & htrans_i[1] & hready_i;
  assign raddr_o = haddr_i[ADDR_W-1:0];

  // capture write address, load read data for zero-wait reply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hready_r <= 1'b1;
      wpend_r <= 1'b0;
      waddr_r <= '0;
      hrdata_r <= RST_WORD;
    end else begin
      hready_r <= 1'b1;
      if (hready_i) begin
        wpend_r <= aphase & hwrite_i;
        waddr_r <= haddr_i[ADDR_W-1:0];
      end
      if (aphase & ~hwrite_i) begin
        hrdata_r <= rdata_i;
      end
    end
  end

  // data phase write strobe with live write data
  assign wr_o = '{en: wpend_r, addr: waddr_r, data: hwdata_i};
  assign hrdata_o = hrdata_r;
  assign hreadyout_o = hready_r;
  assign hresp_o = 1'b0;

endmodule
`default_nettype wire

// file: verification/lppsc_sva.sv
`timescale 1ns/100ps
`default_nettype none
module lppsc_sva
  import lppsc_pkg::*;
#(
  parameter int N_PINS = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus answer
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // power state and pads
  input wire lppsc_state_t pmode_i,
  input wire lppsc_pad_t [N_PINS-1:0] pad_o,
  input wire logic [N_PINS-1:0] core_di_o,
  input wire logic main_osc_en_o,
  input wire logic sub_osc_en_o,
  input wire lppsc_state_t state_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ********************
  // helper flags
  // ********************
  logic [N_PINS-1:0] oe_v;
  logic [N_PINS-1:0] ana_bad_v;
  logic [N_PINS-1:0] leak_v;
  logic [N_PINS-1:0] ie_q;
  logic main_off;
  // per-pin relations between the pad controls
  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      oe_v[i] = pad_o[i].oe;
      ana_bad_v[i] = pad_o[i].ana & (pad_o[i].oe | pad_o[i].ie);
      leak_v[i] = core_di_o[i] & ~pad_o[i].ie & ~ie_q[i];
    end
  end
  // last cycle's input enables, so a closing gate is not flagged early
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < N_PINS; i++) begin
      ie_q[i] <= pad_o[i].ie;
    end
  end
  // states in which the main oscillator is stopped
  assign main_off = state_o inside {ST_TMR_SUB, ST_RTC, ST_STOP, ST_DS_RTC,
                                    ST_DS_STOP};

  // ********************
  // assertions
  // ********************
  sequence mode_ok_s;
    $onehot(pmode_i);
  endsequence
  sequence mode_taken_s;
    ##1 state_o == $past(pmode_i);
  endsequence
  state_follow_a: assert property (mode_ok_s |-> mode_taken_s)
    else $error("state does not follow a valid power mode");
  state_hold_a: assert property (!$onehot(pmode_i) |=> $stable(state_o))
    else $error("state moved on an invalid power mode");
  main_osc_off_a: assert property (main_off |-> !main_osc_en_o)
    else $error("main oscillator runs in a stopped mode");
  main_osc_on_a: assert property (state_o == ST_RUN |-> main_osc_en_o)
    else $error("main oscillator stopped in run");
  sub_osc_run_a: assert property (state_o == ST_RUN |-> sub_osc_en_o)
    else $error("sub oscillator stopped in run");
  por_hiz_a: assert property (state_o == ST_POR |-> oe_v == '0)
    else $error("a pad drives at power-on");
  ana_iso_a: assert property (ana_bad_v == '0)
    else $error("analog pad with driver or digital input on");
  input_gate_a: assert property (leak_v == '0)
    else $error("internal input high while gated");
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready and okay");
endmodule
`default_nettype wire

// file: verification/lppsc_pmc_model.sv
`timescale 1ns/100ps
`default_nettype none
module lppsc_pmc_model
  import lppsc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // state requested by the bench
  input wire logic [12:0] req_i,
  // power state towards the block
  output var lppsc_state_t pmode_o
);
  // power controller moves one edge after a request, power-on at reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pmode_o <= ST_POR;
    end else begin
      pmode_o <= lppsc_state_t'(req_i);
    end
  end
endmodule
`default_nettype wire

// file: verification/low_power_pin_state_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module low_power_pin_state_control_tb;
  import lppsc_pkg::*;
  // ********************
  // signals
  // ********************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic [1:0] htrans_i = 2'b00;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [7:0] act = 8'h00;
  logic [7:0] poe = 8'h00;
  logic [7:0] pdo = 8'h00;
  logic [7:0] pad_di_i = 8'h00;
  logic [12:0] req = 13'h0001;
  logic [31:0] hrdata_o;
  logic [31:0] rd;
  logic hreadyout_o;
  logic hresp_o;
  lppsc_state_t pmode;
  lppsc_state_t state_o;
  lppsc_pad_t [7:0] pad_o;
  lppsc_pad_t sv;
  logic [7:0] core_di_o;
  logic [7:0] blocked_o;
  logic main_osc_en_o;
  logic sub_osc_en_o;
  int error_cnt = 0;
  int cmp_count = 0;

  // clock
  always #5 clk_i = ~clk_i;

  // ********************
  // instances
  // ********************
  lppsc_pmc_model u_lppsc_pmc_model (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req), .pmode_o(pmode));
  lppsc_top u_lppsc_top (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'b010), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .pmode_i(pmode), .periph_act_i(act), .periph_oe_i(poe),
    .periph_do_i(pdo), .pad_di_i(pad_di_i), .pad_o(pad_o),
    .core_di_o(core_di_o), .blocked_o(blocked_o),
    .main_osc_en_o(main_osc_en_o), .sub_osc_en_o(sub_osc_en_o),
    .state_o(state_o));

  // ********************
  // shared tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single ahb-lite transfer, waits on hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'b10;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  // request a state: one edge in the controller, one in the block
  task automatic go(input lppsc_state_t st);
    req <= st;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_regs();
    ahb(1'b0, OFS_STBY_CTL, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, OFS_STBY_CTL, 32'hffff_ffff, rd);
    ahb(1'b0, OFS_STBY_CTL, 32'h0, rd);
    chk(rd, 32'h1);
    ahb(1'b1, OFS_STATE, 32'h8, rd);
    ahb(1'b0, OFS_STATE, 32'h0, rd);
    chk(rd, 32'(ST_POR));
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, OFS_STBY_CTL, 32'h0, rd);
  endtask
  task automatic t_reset_pins();
    pad_di_i <= 8'hff;
    ahb(1'b1, OFS_FUNC_SEL, 32'ha654_3210, rd);
    ahb(1'b1, OFS_PORT_OUT, 32'hff, rd);
    ahb(1'b1, OFS_PORT_DIR, 32'hff, rd);
    chk(32'(pad_o[3]), 32'(PAD_HIZ));
    chk(32'(pad_o[5]), 32'(PAD_HIZ));
    chk(32'(pad_o[1].ie), 32'h1);
    chk(32'(blocked_o[0]), 32'h1);
    go(ST_INIT_LOW);
    chk(32'(pad_o[3]), 32'(PAD_PU));
    chk(32'(pad_o[5]), 32'(PAD_ANA));
    chk(32'(blocked_o[0]), 32'h1);
    go(ST_IRST);
    chk(32'(pad_o[3]), 32'(PAD_PU));
  endtask
  task automatic t_run_stop();
    act <= 8'h10;
    poe <= 8'h10;
    go(ST_RUN);
    chk(32'({pad_o[0].oe, pad_o[0].dout}), 32'h3);
    chk(32'({pad_o[4].oe, pad_o[4].dout}), 32'h2);
    chk(32'(core_di_o[1]), 32'h1);
    chk(32'(core_di_o[5]), 32'h0);
    sv = pad_o[7];
    go(ST_STOP);
    ahb(1'b1, OFS_PORT_OUT, 32'h0, rd);
    pdo <= 8'h10;
    repeat (2) @(posedge clk_i);
    chk(32'(pad_o[0].dout), 32'h1);
    chk(32'(pad_o[4].dout), 32'h1);
    chk(32'({pad_o[6].oe, pad_o[6].ie}), 32'h2);
    chk(32'(pad_o[7]), 32'(sv));
    chk(32'({main_osc_en_o, sub_osc_en_o}), 32'h1);
    chk(32'(pad_o[1].ie), 32'h1);
  endtask
  task automatic t_level1();
    ahb(1'b1, OFS_STBY_CTL, 32'h1, rd);
    ahb(1'b1, OFS_WOSC_CTL, 32'h1, rd);
    ahb(1'b1, OFS_PORT_OUT, 32'hff, rd);
    go(ST_RUN);
    sv = pad_o[6];
    go(ST_TMR_MAIN);
    chk(32'(pad_o[6]), 32'(sv));
    go(ST_RTC);
    chk(32'({pad_o[6].oe, pad_o[6].ie}), 32'h0);
    chk(32'(pad_o[0]), 32'(PAD_IN));
    go(ST_STOP);
    chk(32'({pad_o[7].oe, sub_osc_en_o}), 32'h0);
  endtask
  task automatic t_deep();
    go(ST_DS_STOP);
    chk(32'(pad_o[2]), 32'(PAD_WK));
    chk(32'({pad_o[4].oe, pad_o[4].ie}), 32'h0);
    chk(32'(pad_o[0]), 32'(PAD_IN));
    go(ST_RUN);
    ahb(1'b1, OFS_STBY_CTL, 32'h0, rd);
    go(ST_DS_RTC);
    chk(32'(pad_o[2].wk), 32'h1);
    chk(32'({pad_o[4].oe, pad_o[4].ie}), 32'h2);
    chk(32'({pad_o[0].oe, pad_o[0].ie}), 32'h3);
    go(ST_DS_RET);
    chk(32'({pad_o[2].oe, pad_o[2].ie}), 32'h3);
    go(lppsc_state_t'(13'h0003));
    chk(32'(state_o), 32'(ST_DS_RET));
  endtask
  task automatic t_vbat();
    ahb(1'b1, OFS_FUNC_SEL, 32'h0000_0c9b, rd);
    go(ST_VB_RTC);
    chk(32'(pad_o[1].ie), 32'h1);
    sv = pad_o[2];
    go(ST_VB_RET);
    chk(32'(blocked_o[0]), 32'h1);
    chk(32'(pad_o[1].ie), 32'h1);
    chk(32'(pad_o[2]), 32'(sv));
  endtask

  // ********************
  // main sequence and watchdog
  // ********************
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_reset_pins();
    t_run_stop();
    t_level1();
    t_deep();
    t_vbat();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    end_sim();
  end
endmodule

bind lppsc_top lppsc_sva #(.N_PINS(N_PINS)) u_lppsc_sva (.clk_i(clk_i),
  .rst_i(rst_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .pmode_i(pmode_i), .pad_o(pad_o), .core_di_o(core_di_o),
  .main_osc_en_o(main_osc_en_o), .sub_osc_en_o(sub_osc_en_o),
  .state_o(state_o));
`default_nettype wire
